/* sre_checker_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sre_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Snoop and line state
  input wire logic snp_valid,
  input wire logic snp_ready,
  input wire logic [3:0] snp_type,
  input wire logic line_hit,
  input wire logic line_dirty,
  input wire logic line_unique,
  input wire logic line_err,
  input wire logic keep_pref,
  // Response and actions
  input wire logic resp_valid,
  input wire logic resp_ready,
  input wire logic [4:0] resp_data,
  input wire logic line_invalidate
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire logic tk = snp_valid && snp_ready;
  wire logic inv = snp_type inside {4'h7, 4'h9, 4'hd};
  wire logic rd = snp_type inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h7};
  wire logic ok = tk && line_hit && !line_err;
  ////////////////////////////////////////////////////////////////
  a_pd_needs_dt: assert property (resp_valid |-> !(resp_data[2] && !resp_data[0]))
    else $error("PassDirty without data");
  a_inval_no_share: assert property (tk && inv |=> !resp_data[3])
    else $error("IsShared on invalidating snoop");
  a_inval_pulse: assert property (ok && inv |=> line_invalidate)
    else $error("Line not invalidated");
  a_read_hit_data: assert property (ok && rd |=> resp_data[0])
    else $error("Read hit without data");
  a_mi_no_data: assert property (tk && snp_type == 4'hd |=> !resp_data[0])
    else $error("MakeInvalid returned data");
  a_dirty_pass: assert property (ok && line_dirty && (snp_type inside {4'h7, 4'h9} ||
    (snp_type inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8} && !keep_pref)) |=> resp_data[2])
    else $error("Dirty line dropped without PassDirty");
  a_wu_unique: assert property (tk && !line_unique |=> !resp_data[4])
    else $error("WasUnique on non-unique line");
  a_ro_keep_share: assert property (ok && snp_type == 4'h0 && keep_pref |=> resp_data[3])
    else $error("ReadOnce kept copy without IsShared");
  a_miss_quiet: assert property (tk && !line_hit |=> resp_data[3:0] == 4'h0)
    else $error("Miss gave nonzero response");
  a_wu_set: assert property (ok && line_unique && (rd || inv || snp_type == 4'h8) |=> resp_data[4])
    else $error("WasUnique missing on unique hit");
  a_resp_next: assert property (tk |=> resp_valid)
    else $error("No response after snoop");
  a_resp_hold: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_data))
    else $error("Response changed while stalled");
endmodule : sre_checker
bind sre_encoder sre_checker chk_u (.*);
`default_nettype wire

/* sre_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
module sre_encoder #(
  parameter bit WU_SUPPORT = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Snoop request
  input wire logic snp_valid,
  output logic snp_ready,
  input wire logic [3:0] snp_type,
  // Line state from the cache lookup
  input wire logic line_hit,
  input wire logic line_dirty,
  input wire logic line_unique,
  input wire logic line_err,
  input wire logic keep_pref,
  input wire logic ecc_local_fix,
  // Response channel
  output logic resp_valid,
  input wire logic resp_ready,
  output logic [4:0] resp_data,
  // Cache actions
  output logic line_invalidate,
  output logic line_make_clean,
  output logic illegal_snoop
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Read-type snoops
  function automatic logic is_read(input logic [3:0] t);
    unique case (t)
      sre_pkg::SNP_READ_ONCE,
      sre_pkg::SNP_READ_SHARED,
      sre_pkg::SNP_READ_CLEAN,
      sre_pkg::SNP_READ_NSD,
      sre_pkg::SNP_READ_UNIQUE: begin
        is_read = 1'b1;
      end

      default: begin
        is_read = 1'b0;
      end
    endcase
  endfunction : is_read

  // Snoop types that end with the line invalidated
  function automatic logic is_inval(input logic [3:0] t);
    unique case (t)
      sre_pkg::SNP_READ_UNIQUE,
      sre_pkg::SNP_CLEAN_INVALID,
      sre_pkg::SNP_MAKE_INVALID: begin
        is_inval = 1'b1;
      end

      default: begin
        is_inval = 1'b0;
      end
    endcase
  endfunction : is_inval

  // Snoop types this cache answers
  function automatic logic is_known(input logic [3:0] t);
    unique case (t)
      sre_pkg::SNP_CLEAN_SHARED,
      sre_pkg::SNP_CLEAN_INVALID,
      sre_pkg::SNP_MAKE_INVALID: begin
        is_known = 1'b1;
      end

      default: begin
        is_known = is_read(t);
      end
    endcase
  endfunction : is_known

  // Legal response check: no PassDirty without data, no IsShared on invalidating types
  function automatic logic resp_allowed(input logic [3:0] t, input logic [4:0] r);
    logic no_data_dirty;
    logic shared_inval;
    no_data_dirty = r[sre_pkg::RESP_PD] && !r[sre_pkg::RESP_DT];
    shared_inval = r[sre_pkg::RESP_IS] && is_inval(t);
    resp_allowed = !no_data_dirty && !shared_inval;
  endfunction : resp_allowed

  ////////////////////////////////////////////////////////////////////////////
  // Per-type decisions

  // Whether the copy may stay after the snoop
  function automatic logic keeps_line(input logic [3:0] t, input logic pref);
    unique case (t)
      sre_pkg::SNP_READ_ONCE,
      sre_pkg::SNP_READ_SHARED,
      sre_pkg::SNP_READ_CLEAN,
      sre_pkg::SNP_READ_NSD,
      sre_pkg::SNP_CLEAN_SHARED: begin
        keeps_line = pref;
      end

      default: begin
        keeps_line = 1'b0;
      end
    endcase
  endfunction : keeps_line

  // Whether the line goes out on the data channel
  function automatic logic sends_data(input logic [3:0] t, input logic dirty);
    unique case (t)
      sre_pkg::SNP_READ_ONCE,
      sre_pkg::SNP_READ_SHARED,
      sre_pkg::SNP_READ_CLEAN,
      sre_pkg::SNP_READ_NSD,
      sre_pkg::SNP_READ_UNIQUE: begin
        sends_data = 1'b1;
      end

      sre_pkg::SNP_CLEAN_SHARED,
      sre_pkg::SNP_CLEAN_INVALID: begin
        sends_data = dirty;
      end

      default: begin
        sends_data = 1'b0;
      end
    endcase
  endfunction : sends_data

  // Whether write-back duty leaves this cache
  function automatic logic passes_dirty(input logic [3:0] t, input logic dirty, input logic kept);
    unique case (t)
      sre_pkg::SNP_READ_ONCE: begin
        passes_dirty = dirty && !kept;
      end

      sre_pkg::SNP_READ_SHARED,
      sre_pkg::SNP_READ_CLEAN,
      sre_pkg::SNP_READ_NSD,
      sre_pkg::SNP_CLEAN_SHARED: begin
        passes_dirty = dirty;
      end

      sre_pkg::SNP_READ_UNIQUE,
      sre_pkg::SNP_CLEAN_INVALID: begin
        passes_dirty = dirty;
      end

      default: begin
        passes_dirty = 1'b0;
      end
    endcase
  endfunction : passes_dirty

  // Whether a kept dirty copy turns clean
  function automatic logic cleans_line(input logic [3:0] t, input logic dirty, input logic kept);
    unique case (t)
      sre_pkg::SNP_READ_SHARED,
      sre_pkg::SNP_READ_CLEAN,
      sre_pkg::SNP_READ_NSD,
      sre_pkg::SNP_CLEAN_SHARED: begin
        cleans_line = dirty && kept;
      end

      default: begin
        cleans_line = 1'b0;
      end
    endcase
  endfunction : cleans_line

  ////////////////////////////////////////////////////////////////////////////
  // Response formation

  // Response before and after the legality net
  logic [4:0] resp_form;
  logic [4:0] resp_d;
  // Decisions for the snoop on the bus
  logic type_known;
  logic keep;
  logic hit_eff;
  logic inval_d;
  logic clean_d;
  logic take;

  // Clean line in error is dropped locally when ecc_local_fix is set, otherwise flagged
  always_comb begin
    resp_form = sre_pkg::RESP_RESET;
    type_known = is_known(snp_type);
    hit_eff = line_hit && !(line_err && ecc_local_fix && !line_dirty);
    keep = 1'b0;
    clean_d = 1'b0;
    if (hit_eff && type_known) begin
      keep = keeps_line(snp_type, keep_pref) && !is_inval(snp_type);
      clean_d = cleans_line(snp_type, line_dirty, keep);
      resp_form[sre_pkg::RESP_DT] = sends_data(snp_type, line_dirty);
      resp_form[sre_pkg::RESP_PD] = passes_dirty(snp_type, line_dirty, keep);
      resp_form[sre_pkg::RESP_IS] = keep;
      resp_form[sre_pkg::RESP_WU] = WU_SUPPORT && line_unique;
      resp_form[sre_pkg::RESP_ERR] = line_err;
    end
  end

  // Safety net: a response that fails resp_allowed collapses to all zero
  always_comb begin
    resp_d = resp_form;
    if (!resp_allowed(snp_type, resp_form)) begin
      resp_d = sre_pkg::RESP_RESET;
    end
    // Never PassDirty without data
    if (!resp_d[sre_pkg::RESP_DT]) begin
      resp_d[sre_pkg::RESP_PD] = 1'b0;
    end
  end

  // Line actions follow the retain decision
  always_comb begin
    inval_d = 1'b0;
    if (hit_eff && type_known) begin
      inval_d = !keep;
    end else if (line_hit && type_known) begin
      inval_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One response per snoop, in order

  // A new snoop is taken while no response is pending or while resp_ready accepts the pending one
  assign snp_ready = !resp_valid || resp_ready;
  assign take = snp_valid && snp_ready;

  // Response valid until the interconnect takes it
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      resp_valid <= 1'b0;
    end else if (take) begin
      resp_valid <= 1'b1;
    end else if (resp_ready) begin
      resp_valid <= 1'b0;
    end
  end

  // Response bits held while pending
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      resp_data <= sre_pkg::RESP_RESET;
    end else if (take) begin
      resp_data <= resp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cache action pulses

  // Invalidate pulse
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      line_invalidate <= 1'b0;
    end else begin
      line_invalidate <= take && inval_d;
    end
  end

  // Make-clean pulse
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      line_make_clean <= 1'b0;
    end else begin
      line_make_clean <= take && clean_d;
    end
  end

  // Unknown snoop type pulse
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      illegal_snoop <= 1'b0;
    end else begin
      illegal_snoop <= take && !type_known;
    end
  end

endmodule : sre_encoder
`default_nettype wire

/* sre_icn_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sre_icn_model (
  // Clock and stall control
  input wire logic core_clk,
  input wire logic slow,
  // Response channel
  output logic resp_ready = 1'b1
);
  logic [1:0] cnt_q = 2'h0;
  // Takes any legal response, extra data too, never ends the snoop early
  always @(posedge core_clk) begin
    cnt_q <= cnt_q + 2'h1;
    resp_ready <= #1 !slow || (cnt_q == 2'h3);
  end
endmodule : sre_icn_model
`default_nettype wire

/* sre_pkg.sv */
package sre_pkg;
  // Snoop type encodings
  localparam logic [3:0] SNP_READ_ONCE = 4'h0;
  localparam logic [3:0] SNP_READ_SHARED = 4'h1;
  localparam logic [3:0] SNP_READ_CLEAN = 4'h2;
  localparam logic [3:0] SNP_READ_NSD = 4'h3;
  localparam logic [3:0] SNP_READ_UNIQUE = 4'h7;
  localparam logic [3:0] SNP_CLEAN_SHARED = 4'h8;
  localparam logic [3:0] SNP_CLEAN_INVALID = 4'h9;
  localparam logic [3:0] SNP_MAKE_INVALID = 4'hd;
  // Response bit positions
  localparam int RESP_DT = 0;
  localparam int RESP_ERR = 1;
  localparam int RESP_PD = 2;
  localparam int RESP_IS = 3;
  localparam int RESP_WU = 4;
  localparam logic [4:0] RESP_RESET = 5'h00;
  // Line state after the lookup
  typedef struct packed {
    logic hit;
    logic dirty;
    logic unique_st;
    logic err;
  } sre_line_t;
endpackage : sre_pkg

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 0, nrst = 0, snp_valid = 0, slow = 0, keep_pref = 0, ecc_local_fix = 0;
  logic line_hit = 0, line_dirty = 0, line_unique = 0, line_err = 0;
  logic [3:0] snp_type = 4'h0;
  logic [4:0] resp_data;
  logic snp_ready, resp_valid, resp_ready, line_invalidate, line_make_clean, illegal_snoop;
  logic [3:0] exp_q[$], msk_q[$];
  int failures = 0, samples_checked = 0;
  sre_encoder dut_u (.*);
  sre_icn_model icn_u (.*);
  initial forever #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  function automatic logic bad_type(input logic [3:0] t);
    return !(t inside {sre_pkg::SNP_READ_ONCE, sre_pkg::SNP_READ_SHARED, sre_pkg::SNP_READ_CLEAN,
      sre_pkg::SNP_READ_NSD, sre_pkg::SNP_READ_UNIQUE, sre_pkg::SNP_CLEAN_SHARED,
      sre_pkg::SNP_CLEAN_INVALID, sre_pkg::SNP_MAKE_INVALID});
  endfunction : bad_type
  task automatic snoop(input logic [3:0] t, input logic [5:0] st, input logic [3:0] e, m,
    input logic [2:0] p);
    @(posedge core_clk) #1;
    {line_hit, line_dirty, line_unique, line_err, keep_pref, ecc_local_fix} = st;
    snp_type = t;
    snp_valid = 1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    do @(negedge core_clk); while (snp_ready !== 1'b1);
    @(posedge core_clk) #1 snp_valid = 0;
    samples_checked++;
    if ({line_invalidate, line_make_clean, illegal_snoop} !== p) begin
      failures++;
      $display("[FAIL] %0t bad line action %b", $time, {line_invalidate, line_make_clean, illegal_snoop});
    end
  endtask : snoop
  always @(posedge core_clk) if (nrst && resp_valid && resp_ready) begin
    samples_checked++;
    if ((resp_data[3:0] & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
      failures++;
      $display("[FAIL] %0t bad response %b", $time, resp_data);
    end
    void'(exp_q.pop_front());
    void'(msk_q.pop_front());
  end
  initial begin
    #20000;
    failures++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk);
    #1 nrst = 1;
    for (int t = 0; t < 16; t++) snoop(t[3:0], 6'b000000, 4'h0, 4'hf, {2'b00, bad_type(t[3:0])});
    snoop(4'h7, 6'b111010, 4'b0101, 4'hf, 3'b100);
    snoop(4'h0, 6'b101010, 4'b1001, 4'hf, 3'b000);
    snoop(4'h1, 6'b110010, 4'b1101, 4'hf, 3'b010);
    snoop(4'h8, 6'b110000, 4'b0101, 4'hf, 3'b100);
    snoop(4'h8, 6'b100010, 4'b1000, 4'b1100, 3'b000);
    snoop(4'hd, 6'b110010, 4'b0000, 4'hf, 3'b100);
    snoop(4'h9, 6'b100010, 4'b0000, 4'b1100, 3'b100);
    snoop(4'h2, 6'b100100, 4'b0010, 4'b0010, 3'b100);
    snoop(4'h2, 6'b100101, 4'b0000, 4'hf, 3'b100);
    slow = 1;
    foreach (exp_q[i]) @(posedge core_clk);
    for (int t = 0; t < 4; t++) snoop(t[3:0], 6'b110000, 4'b0101, 4'hf, 3'b100);
    repeat (40) @(posedge core_clk);
    if (exp_q.size() != 0) failures++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
